// ---- rtl/ipr_pkg.sv ----
package ipr_pkg;

   localparam int IPR_NUM_REGS = 6;
   localparam int IPR_NUM_SRC  = 18;
   localparam int IPR_FIELD_W  = 3;
   localparam int IPR_SRC_W    = 5;
   localparam int IPR_REG_W    = 16;
   localparam int IPR_DATA_W   = 32;
   localparam int IPR_IDX_W    = 3;

   typedef logic [IPR_REG_W-1:0]   ipr_word_t;
   typedef logic [IPR_FIELD_W-1:0] ipr_level_t;

   ////////////////////////////////////////////////////////////////////////////
   // Register map, byte addresses on the register bus
   localparam logic [7:0] IPR_OFS [IPR_NUM_REGS] = '{
      8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14};

   // Bits that hold a level field; all other bits are tied to zero
   localparam ipr_word_t IPR_IMPL_MASK [IPR_NUM_REGS] = '{
      16'h7777, 16'h7770, 16'h7777, 16'h0077, 16'h7777, 16'h0007};

   // Every field comes up at level four
   localparam ipr_level_t IPR_FIELD_RST = 3'h4;
   localparam ipr_word_t  IPR_RST_VAL [IPR_NUM_REGS] = '{
      16'h4444, 16'h4440, 16'h4444, 16'h0044, 16'h4444, 16'h0004};

   localparam ipr_level_t IPR_LVL_OFF = 3'h0;

   ////////////////////////////////////////////////////////////////////////////
   // Source numbering: register index and field lsb of each source
   // 0 timer_one_level       1 compare_one_level   2 capture_one_level
   // 3 ext_irq_zero_level    4 timer_two_level     5 compare_two_level
   // 6 capture_two_level     7 serial_one_rx_level 8 sync_serial_one_event_level
   // 9 sync_serial_one_fault_level 10 timer_three_level 11 adc_done_level
   // 12 serial_one_tx_level  13 pin_change_level   14 comparator_level
   // 15 two_wire_master_level 16 two_wire_slave_level 17 ext_irq_one_level
   localparam int IPR_SRC_REG [IPR_NUM_SRC] = '{
      0, 0, 0, 0, 1, 1, 1, 2, 2, 2, 2, 3, 3, 4, 4, 4, 4, 5};
   localparam int IPR_SRC_LSB [IPR_NUM_SRC] = '{
      12, 8, 4, 0, 12, 8, 4, 12, 8, 4, 0, 4, 0, 12, 8, 4, 0, 0};

   localparam logic [1:0] IPR_RESP_OKAY   = 2'h0;
   localparam logic [1:0] IPR_RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic                 valid;
      logic [IPR_SRC_W-1:0] source;
      ipr_level_t           level;
   } ipr_req_s;

endpackage : ipr_pkg

// ---- rtl/ipr_arbiter.sv ----
`timescale 1ns/1ps
module ipr_arbiter
   import ipr_pkg::*;
#(
   parameter int NUM_SRC = IPR_NUM_SRC
) (
   input  wire logic                           aclk,
   input  wire logic                           aresetn,
   input  wire logic [NUM_SRC*IPR_FIELD_W-1:0] levels,
   input  wire logic [NUM_SRC-1:0]             pending,
   output      ipr_req_s                       req
);

   if (NUM_SRC < 2 || NUM_SRC > (1 << IPR_SRC_W)) begin : g_bad_num
      $error("ipr_arbiter: NUM_SRC out of range");
   end

   ipr_req_s   req_ff;
   ipr_level_t best_lvl;
   logic [IPR_SRC_W-1:0] best_idx;
   logic [NUM_SRC-1:0]   pend_ff;

   ////////////////////////////////////////////////////////////////////////////
   // zero never wins
   // Strict compare: on equal levels the lower source number keeps the grant
   always_comb begin
      best_lvl = IPR_LVL_OFF;
      best_idx = '0;
      for (int i = 0; i < NUM_SRC; i++) begin
         if (pending[i] && (levels[i*IPR_FIELD_W +: IPR_FIELD_W] > best_lvl)) begin
            best_lvl = levels[i*IPR_FIELD_W +: IPR_FIELD_W];
            best_idx = IPR_SRC_W'(i);
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         req_ff <= '0;
      end else begin
         req_ff.valid  <= (best_lvl != IPR_LVL_OFF);
         req_ff.source <= best_idx;
         req_ff.level  <= best_lvl;
      end
   end

   assign req = req_ff;

   // Pending vector as the grant saw it, indexed by the grant's own source
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pend_ff <= '0;
      end else begin
         pend_ff <= pending;
      end
   end

   chk_disabled_never : assert property (
      @(posedge aclk) disable iff (!aresetn)
      req_ff.valid |-> (req_ff.level != IPR_LVL_OFF) && pend_ff[req_ff.source])
      else $error("granted source at level zero or not pending");

endmodule : ipr_arbiter

// ---- rtl/ipr_top.sv ----
// Implementation choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
// Contract
// - Three-bit level field; 111 gives level 7, the highest.
// - Field value 001 gives level 1, lowest serviced level.
// - Field value 000 disables the source completely.
// - Unused bits, bit 15 and gaps, always read zero.
// - Reset loads 100 into every field, level 4.
// - Register 0: timer1 14-12, compare1 10-8, capture1 6-4, ext0 2-0.
// - Register 1: timer2 14-12, compare2 10-8, capture2 6-4; 3-0 unused.
// - Register 2: serial rx 14-12, spi event 10-8, spi fault 6-4, timer3 2-0.
// - Register 3: bits 15-7 unused; adc 6-4, serial tx 2-0.
// - Register 4: pin change, comparator, two-wire master, two-wire slave.
// - Register 5: only ext1 in bits 2-0.
// - Source with enable cleared never requests, whatever its level.
module ipr_top
   import ipr_pkg::*;
#(
   parameter int ADDR_W = 8
) (
   input  wire logic                   aclk,
   input  wire logic                   aresetn,
   input  wire logic [ADDR_W-1:0]      s_axi_awaddr,
   input  wire logic                   s_axi_awvalid,
   output      logic                   s_axi_awready,
   input  wire logic [IPR_DATA_W-1:0]  s_axi_wdata,
   input  wire logic [3:0]             s_axi_wstrb,
   input  wire logic                   s_axi_wvalid,
   output      logic                   s_axi_wready,
   output      logic [1:0]             s_axi_bresp,
   output      logic                   s_axi_bvalid,
   input  wire logic                   s_axi_bready,
   input  wire logic [ADDR_W-1:0]      s_axi_araddr,
   input  wire logic                   s_axi_arvalid,
   output      logic                   s_axi_arready,
   output      logic [IPR_DATA_W-1:0]  s_axi_rdata,
   output      logic [1:0]             s_axi_rresp,
   output      logic                   s_axi_rvalid,
   input  wire logic                   s_axi_rready,
   input  wire logic [IPR_NUM_SRC-1:0] src_flag,
   input  wire logic [IPR_NUM_SRC-1:0] src_enable,
   output      ipr_req_s               irq_req
);

   if (ADDR_W < 5 || ADDR_W > 32) begin : g_bad_addr
      $error("ipr_top: ADDR_W out of range");
   end

   ////////////////////////////////////////////////////////////////////////////
   // Address decode, shared by the read and the write path

   function automatic logic reg_hit(input logic [ADDR_W-1:0] addr);
      logic hit;
      hit = 1'b0;
      for (int i = 0; i < IPR_NUM_REGS; i++) begin
         if ({addr[ADDR_W-1:2], 2'b00} == ADDR_W'(IPR_OFS[i])) begin
            hit = 1'b1;
         end
      end
      return hit;
   endfunction : reg_hit

   function automatic logic [IPR_IDX_W-1:0] reg_idx(input logic [ADDR_W-1:0] addr);
      logic [IPR_IDX_W-1:0] idx;
      idx = '0;
      for (int i = 0; i < IPR_NUM_REGS; i++) begin
         if ({addr[ADDR_W-1:2], 2'b00} == ADDR_W'(IPR_OFS[i])) begin
            idx = IPR_IDX_W'(i);
         end
      end
      return idx;
   endfunction : reg_idx

   ////////////////////////////////////////////////////////////////////////////
   // Declarations

   ipr_word_t             prio_ff [IPR_NUM_REGS];
   logic                  awready_ff;
   logic                  wready_ff;
   logic                  aw_held_ff;
   logic                  w_held_ff;
   logic [ADDR_W-1:0]     awaddr_ff;
   logic [IPR_DATA_W-1:0] wdata_ff;
   logic [3:0]            wstrb_ff;
   logic                  bvalid_ff;
   logic [1:0]            bresp_ff;
   logic                  arready_ff;
   logic                  rd_pend_ff;
   logic [ADDR_W-1:0]     araddr_ff;
   logic                  rvalid_ff;
   logic [IPR_DATA_W-1:0] rdata_ff;
   logic [1:0]            rresp_ff;
   logic                  wr_fire;
   logic                  wr_hit;
   logic [IPR_IDX_W-1:0]  widx;
   ipr_word_t             nxt_prio;
   logic [IPR_NUM_SRC*IPR_FIELD_W-1:0] lvl_vec;
   logic [IPR_NUM_SRC-1:0]             pending;

   ////////////////////////////////////////////////////////////////////////////
   // Write address channel

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_ff <= 1'b0;
         aw_held_ff <= 1'b0;
         awaddr_ff  <= '0;
      end else if (s_axi_awvalid && awready_ff) begin
         awready_ff <= 1'b0;
         aw_held_ff <= 1'b1;
         awaddr_ff  <= s_axi_awaddr;
      end else if (wr_fire) begin
         awready_ff <= 1'b1;
         aw_held_ff <= 1'b0;
      end else if (!aw_held_ff) begin
         awready_ff <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Write data channel

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wready_ff <= 1'b0;
         w_held_ff <= 1'b0;
         wdata_ff  <= '0;
         wstrb_ff  <= '0;
      end else if (s_axi_wvalid && wready_ff) begin
         wready_ff <= 1'b0;
         w_held_ff <= 1'b1;
         wdata_ff  <= s_axi_wdata;
         wstrb_ff  <= s_axi_wstrb;
      end else if (wr_fire) begin
         wready_ff <= 1'b1;
         w_held_ff <= 1'b0;
      end else if (!w_held_ff) begin
         wready_ff <= 1'b1;
      end
   end

   // Address and data may arrive in either order; the write waits for both
   // and for the previous response to be taken
   assign wr_fire = aw_held_ff && w_held_ff && !bvalid_ff;
   assign wr_hit  = reg_hit(awaddr_ff);
   assign widx    = reg_idx(awaddr_ff);

   ////////////////////////////////////////////////////////////////////////////
   // Write response

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_ff <= 1'b0;
         bresp_ff  <= IPR_RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_ff <= 1'b1;
         bresp_ff  <= wr_hit ? IPR_RESP_OKAY : IPR_RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_ff <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Priority registers

   // unused bits masked
   // Only lanes 0 and 1 carry register bits; lanes 2 and 3 are dropped
   always_comb begin
      nxt_prio = prio_ff[widx];
      if (wstrb_ff[0]) begin
         nxt_prio[7:0] = wdata_ff[7:0];
      end
      if (wstrb_ff[1]) begin
         nxt_prio[15:8] = wdata_ff[15:8];
      end
      nxt_prio = nxt_prio & IPR_IMPL_MASK[widx];
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int i = 0; i < IPR_NUM_REGS; i++) begin
            prio_ff[i] <= IPR_RST_VAL[i];
         end
      end else if (wr_fire && wr_hit) begin
         prio_ff[widx] <= nxt_prio;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read channels

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_ff <= 1'b0;
         rd_pend_ff <= 1'b0;
         araddr_ff  <= '0;
      end else if (s_axi_arvalid && arready_ff) begin
         arready_ff <= 1'b0;
         rd_pend_ff <= 1'b1;
         araddr_ff  <= s_axi_araddr;
      end else if (rd_pend_ff) begin
         rd_pend_ff <= 1'b0;
      end else if (!rvalid_ff) begin
         arready_ff <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_ff <= 1'b0;
         rdata_ff  <= '0;
         rresp_ff  <= IPR_RESP_OKAY;
      end else if (rd_pend_ff) begin
         rvalid_ff <= 1'b1;
         if (reg_hit(araddr_ff)) begin
            rdata_ff <= {{(IPR_DATA_W-IPR_REG_W){1'b0}}, prio_ff[reg_idx(araddr_ff)]};
            rresp_ff <= IPR_RESP_OKAY;
         end else begin
            rdata_ff <= '0;
            rresp_ff <= IPR_RESP_SLVERR;
         end
      end else if (s_axi_rready) begin
         rvalid_ff <= 1'b0;
      end
   end

   assign s_axi_awready = awready_ff;
   assign s_axi_wready  = wready_ff;
   assign s_axi_bvalid  = bvalid_ff;
   assign s_axi_bresp   = bresp_ff;
   assign s_axi_arready = arready_ff;
   assign s_axi_rvalid  = rvalid_ff;
   assign s_axi_rdata   = rdata_ff;
   assign s_axi_rresp   = rresp_ff;

   ////////////////////////////////////////////////////////////////////////////
   // Field extraction and request gating

   for (genvar g = 0; g < IPR_NUM_SRC; g++) begin : g_src
      assign lvl_vec[g*IPR_FIELD_W +: IPR_FIELD_W] =
         prio_ff[IPR_SRC_REG[g]][IPR_SRC_LSB[g] +: IPR_FIELD_W];
   end

   assign pending = src_flag & src_enable;

   ipr_arbiter #(
      .NUM_SRC (IPR_NUM_SRC)
   ) u_arbiter (
      .aclk    (aclk),
      .aresetn (aresetn),
      .levels  (lvl_vec),
      .pending (pending),
      .req     (irq_req)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   logic                 rst_match;
   logic                 lw_vld_ff;
   logic [IPR_IDX_W-1:0] lw_idx_ff;
   logic [7:0]           lw_low_ff;
   logic [IPR_NUM_SRC-1:0]             src_en_ff;
   logic [IPR_NUM_SRC-1:0]             src_fl_ff;
   logic [IPR_NUM_SRC*IPR_FIELD_W-1:0] lvl_vec_ff;

   always_comb begin
      rst_match = 1'b1;
      for (int i = 0; i < IPR_NUM_REGS; i++) begin
         if (prio_ff[i] != IPR_RST_VAL[i]) begin
            rst_match = 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         lw_vld_ff <= 1'b0;
         lw_idx_ff <= '0;
         lw_low_ff <= '0;
         src_en_ff  <= '0;
         src_fl_ff  <= '0;
         lvl_vec_ff <= '0;
      end else begin
         src_en_ff  <= src_enable;
         src_fl_ff  <= src_flag;
         lvl_vec_ff <= lvl_vec;
         lw_vld_ff <= wr_fire && wr_hit && wstrb_ff[0];
         lw_idx_ff <= widx;
         lw_low_ff <= wdata_ff[7:0] & IPR_IMPL_MASK[widx][7:0];
      end
   end

   chk_reset_value : assert property (
      @(posedge aclk) disable iff (!aresetn)
      ($past(aresetn) == 1'b0) |-> rst_match)
      else $error("registers not at level four after reset");

   chk_unimpl_zero : assert property (
      @(posedge aclk) disable iff (!aresetn)
      (prio_ff[1] & ~IPR_IMPL_MASK[1]) == '0 && (prio_ff[3] & ~IPR_IMPL_MASK[3]) == '0
      && (prio_ff[5] & ~IPR_IMPL_MASK[5]) == '0 && (prio_ff[0] & ~IPR_IMPL_MASK[0]) == '0
      && (prio_ff[2] & ~IPR_IMPL_MASK[2]) == '0 && (prio_ff[4] & ~IPR_IMPL_MASK[4]) == '0)
      else $error("unused register bit set");

   chk_read_upper : assert property (
      @(posedge aclk) disable iff (!aresetn)
      s_axi_rvalid |-> (s_axi_rdata[IPR_DATA_W-1:IPR_REG_W] == '0)
                       && ((s_axi_rdata[IPR_REG_W-1:0] & 16'h8888) == 16'h0000))
      else $error("read data carries bits outside the fields");

   chk_write_lands : assert property (
      @(posedge aclk) disable iff (!aresetn)
      lw_vld_ff |-> prio_ff[lw_idx_ff][7:0] == lw_low_ff)
      else $error("low byte write did not land");

   chk_write_resp : assert property (
      @(posedge aclk) disable iff (!aresetn)
      wr_fire |=> s_axi_bvalid && (s_axi_bresp == ($past(wr_hit) ? IPR_RESP_OKAY
                                                               : IPR_RESP_SLVERR)))
      else $error("write response missing or wrong");

   chk_enable_gate : assert property (
      @(posedge aclk) disable iff (!aresetn)
      irq_req.valid |-> src_en_ff[irq_req.source] && src_fl_ff[irq_req.source])
      else $error("request from a disabled source");

   chk_level_match : assert property (
      @(posedge aclk) disable iff (!aresetn)
      irq_req.valid |-> irq_req.level == lvl_vec_ff[irq_req.source*IPR_FIELD_W +: IPR_FIELD_W])
      else $error("granted level differs from field value");

   chk_rdata_hold : assert property (
      @(posedge aclk) disable iff (!aresetn)
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped before taken");

   chk_read_latency : assert property (
      @(posedge aclk) disable iff (!aresetn)
      s_axi_arvalid && s_axi_arready |=> ##1 s_axi_rvalid)
      else $error("read answer not two cycles after address");

endmodule : ipr_top

// ---- testbench/ipr_top_test.sv ----
`timescale 1ns/1ps
module ipr_top_test
   import ipr_pkg::*;
;
   logic                   aclk;
   logic                   aresetn;
   logic [7:0]             s_axi_awaddr;
   logic                   s_axi_awvalid;
   logic                   s_axi_awready;
   logic [IPR_DATA_W-1:0]  s_axi_wdata;
   logic [3:0]             s_axi_wstrb;
   logic                   s_axi_wvalid;
   logic                   s_axi_wready;
   logic [1:0]             s_axi_bresp;
   logic                   s_axi_bvalid;
   logic                   s_axi_bready;
   logic [7:0]             s_axi_araddr;
   logic                   s_axi_arvalid;
   logic                   s_axi_arready;
   logic [IPR_DATA_W-1:0]  s_axi_rdata;
   logic [1:0]             s_axi_rresp;
   logic                   s_axi_rvalid;
   logic                   s_axi_rready;
   logic [IPR_NUM_SRC-1:0] src_flag;
   logic [IPR_NUM_SRC-1:0] src_enable;
   ipr_req_s               irq_req;
   int                     bad_count;
   int                     samples_checked;
   ipr_level_t             lv [IPR_NUM_SRC];
   logic [31:0]            rdat;
   logic [1:0]             resp;

   ipr_top #(.ADDR_W(8)) dut_u (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .src_flag(src_flag),
      .src_enable(src_enable), .irq_req(irq_req));

   initial begin
      aclk = 1'b0;
      forever #12.5 aclk = ~aclk;
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic close_out();
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : close_out

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic tmo();
      bad_count++;
      $display("[ERR] %0t bus handshake timed out", $time);
      close_out();
   endtask : tmo

   // Reference state: one level per source, rebuilt into words on demand
   function automatic ipr_word_t exp_reg(input int k);
      ipr_word_t w;
      w = '0;
      for (int i = 0; i < IPR_NUM_SRC; i++) begin
         if (IPR_SRC_REG[i] == k) w[IPR_SRC_LSB[i] +: 3] = lv[i];
      end
      return w;
   endfunction : exp_reg

   // strict compare keeps lowest source on ties
   function automatic ipr_req_s exp_req(input logic [IPR_NUM_SRC-1:0] en,
                                        input logic [IPR_NUM_SRC-1:0] fl);
      ipr_req_s q;
      q = '0;
      for (int i = 0; i < IPR_NUM_SRC; i++) begin
         if (en[i] && fl[i] && lv[i] > q.level) begin
            q.valid  = 1'b1;
            q.source = IPR_SRC_W'(i);
            q.level  = lv[i];
         end
      end
      return q;
   endfunction : exp_req

   task automatic upd(input int k, input logic [31:0] d, input logic [3:0] s);
      for (int i = 0; i < IPR_NUM_SRC; i++) begin
         if (IPR_SRC_REG[i] == k && s[IPR_SRC_LSB[i] / 8]) lv[i] = d[IPR_SRC_LSB[i] +: 3];
      end
   endtask : upd

   // Called right after a rising edge; returns at the response edge
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                     output logic [1:0] r);
      bit aw_d;
      bit w_d;
      int n;
      aw_d = 1'b0;
      w_d = 1'b0;
      n = 0;
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_wvalid <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (!aw_d && s_axi_awready) begin
            aw_d = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (!w_d && s_axi_wready) begin
            w_d = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end while (!(aw_d && w_d && s_axi_bvalid) && n < 200);
      if (n >= 200) tmo();
      r = s_axi_bresp;
   endtask : wr

   // Lag holds rready low for that many edges so the slave must keep its answer
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r,
                     input int lag);
      bit a_d;
      int n;
      a_d = 1'b0;
      n = 0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      if (lag > 0) s_axi_rready <= 1'b0;
      do begin
         @(posedge aclk);
         n++;
         if (!a_d && s_axi_arready) begin
            a_d = 1'b1;
            s_axi_arvalid <= 1'b0;
         end
         if (n >= lag && !s_axi_rready) s_axi_rready <= 1'b1;
      end while (!(a_d && s_axi_rvalid && s_axi_rready) && n < 200);
      if (n >= 200) tmo();
      d = s_axi_rdata;
      r = s_axi_rresp;
   endtask : rd

   task automatic chkregs();
      for (int k = 0; k < IPR_NUM_REGS; k++) begin
         rd(IPR_OFS[k], rdat, resp, 0);
         chk(rdat, {16'h0000, exp_reg(k)});
         chk(32'(resp), 32'(IPR_RESP_OKAY));
      end
   endtask : chkregs

   task automatic rst();
      aresetn <= 1'b0;
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      for (int i = 0; i < IPR_NUM_SRC; i++) lv[i] = IPR_FIELD_RST;
      @(posedge aclk);
   endtask : rst

   task automatic chkarb(input logic [IPR_NUM_SRC-1:0] en, input logic [IPR_NUM_SRC-1:0] fl);
      src_enable <= en;
      src_flag <= fl;
      repeat (2) @(posedge aclk);
      chk({23'h0, irq_req}, {23'h0, exp_req(en, fl)});
   endtask : chkarb

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
      {s_axi_araddr, s_axi_arvalid, src_flag, src_enable} = '0;
      // Ready on both answer channels except while rd holds rready low for its lag: a legal and simple master
      s_axi_bready = 1'b1;
      s_axi_rready = 1'b1;
      aresetn = 1'b0;
      bad_count = 0;
      samples_checked = 0;
      void'($urandom(52983));
      rst();
      chkregs();
      for (int k = 0; k < IPR_NUM_REGS; k++) begin
         wr(IPR_OFS[k], 32'hFFFF_FFFF, 4'hF, resp);
         upd(k, 32'hFFFF_FFFF, 4'hF);
      end
      chkregs();
      chkarb('1, '1);
      // Sweep every encoding on the lone enabled source, checked one edge later
      src_enable <= 18'h20000;
      src_flag <= '1;
      for (int v = 0; v < 8; v++) begin
         wr(8'h14, 32'(v), 4'h1, resp);
         upd(5, 32'(v), 4'h1);
         @(posedge aclk);
         chk({23'h0, irq_req}, {23'h0, exp_req(18'h20000, '1)});
      end
      chkarb('0, '1);
      wr(8'h18, 32'h0000_7777, 4'hF, resp);
      chk(32'(resp), 32'(IPR_RESP_SLVERR));
      rd(8'hFC, rdat, resp, 2);
      chk(rdat, 32'h0);
      chk(32'(resp), 32'(IPR_RESP_SLVERR));
      for (int t = 0; t < 40; t++) begin
         int          k;
         logic [31:0] d;
         logic [3:0]  s;
         k = $urandom_range(5);
         d = $urandom;
         s = 4'($urandom);
         wr(IPR_OFS[k], d, s, resp);
         chk(32'(resp), 32'(IPR_RESP_OKAY));
         upd(k, d, s);
         rd(IPR_OFS[k], rdat, resp, $urandom_range(4));
         chk(rdat, {16'h0000, exp_reg(k)});
         chk(32'(resp), 32'(IPR_RESP_OKAY));
         chkarb(IPR_NUM_SRC'($urandom), IPR_NUM_SRC'($urandom));
      end
      rst();
      chkregs();
      chkarb('1, '1);
      close_out();
   end
endmodule : ipr_top_test
